// ---- rtl/csae_pkg.sv ----
/*
 * shared constants and carriers of the chip-select area enable block.
 * assumes one core clock; no software-reachable registers.
 */
package csae_pkg;
    localparam int CSAE_AREAS = 8;
    localparam int CSAE_AREA_W = 3;
    localparam logic [7:0] CSAE_EN_RST = 8'h01;
    // half period of the shared bus / dram clock, in core cycles
    localparam int CSAE_CLK_HALF = 2;

    typedef struct packed {
        logic valid;
        logic [CSAE_AREA_W-1:0] area;
    } csae_req_s;

    typedef struct packed {
        logic level;
        logic oe;
    } csae_clk_pin_s;
endpackage : csae_pkg

// ---- rtl/csae_top.sv ----
/*
 * chip-select area enable logic: per-area operation enables, access
 * filtering and the shared bus / dram clock outputs.
 * assumes requests and configuration come from logic on core_clk.
 */
`timescale 1ns/1ns

module csae_top
    import csae_pkg::*;
#(
    parameter int CLK_HALF = CSAE_CLK_HALF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic en_wr,
    input wire logic [CSAE_AREAS-1:0] en_wdata,
    input wire csae_req_s acc_req,
    input wire logic dram_clock_output_enable,
    input wire logic bus_clock_output_pin,
    output logic [CSAE_AREAS-1:0] area_operation_enable,
    output logic [CSAE_AREAS-1:0] cs_strobe,
    output logic acc_ignored,
    output csae_clk_pin_s bus_clk_pin,
    output csae_clk_pin_s sync_dram_clock_out
);
    if (CLK_HALF < 1 || CLK_HALF > 255) begin : g_bad_half
        $error("CLK_HALF out of range");
    end

    function automatic logic [CSAE_AREAS-1:0] onehot(
        input logic [CSAE_AREA_W-1:0] a);
        onehot = 8'h01 << a;
    endfunction : onehot

    // enables and access filter
    logic [CSAE_AREAS-1:0] en_q, en_d, cs_q, cs_d;
    logic ign_q, ign_d;

    always_comb begin
        en_d = en_wr ? en_wdata : en_q;
        cs_d = 8'h00;
        ign_d = 1'b0;
        if (acc_req.valid) begin
            if (en_q[acc_req.area]) begin
                cs_d = onehot(acc_req.area);
            end else begin
                ign_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_q <= CSAE_EN_RST;
            cs_q <= 8'h00;
            ign_q <= 1'b0;
        end else begin
            en_q <= en_d;
            cs_q <= cs_d;
            ign_q <= ign_d;
        end
    end

    assign area_operation_enable = en_q;
    assign cs_strobe = cs_q;
    assign acc_ignored = ign_q;

    // one divider feeds both clock pins so they cannot drift apart
    logic [7:0] div_q, div_d;
    logic tgl_q, tgl_d;
    csae_clk_pin_s bclk_q, bclk_d, sync_dram_clock_out_q, sync_dram_clock_out_d;

    always_comb begin
        div_d = div_q + 8'h01;
        tgl_d = tgl_q;
        if (div_q == 8'(CLK_HALF - 1)) begin
            div_d = 8'h00;
            tgl_d = ~tgl_q;
        end
        bclk_d.oe = bus_clock_output_pin;
        bclk_d.level = tgl_d & bus_clock_output_pin;
        // cleared enable parks the pin low and releases it
        sync_dram_clock_out_d.oe = dram_clock_output_enable;
        sync_dram_clock_out_d.level = tgl_d & dram_clock_output_enable;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= 8'h00;
            tgl_q <= 1'b0;
            bclk_q <= '0;
            sync_dram_clock_out_q <= '0;
        end else begin
            div_q <= div_d;
            tgl_q <= tgl_d;
            bclk_q <= bclk_d;
            sync_dram_clock_out_q <= sync_dram_clock_out_d;
        end
    end

    assign bus_clk_pin = bclk_q;
    assign sync_dram_clock_out = sync_dram_clock_out_q;

    // cycles since the shared toggle last flipped; reset loads all ones, which
    // wrap to zero on the first clock, so the first half period counts in full
    logic [7:0] hp_q, hp_d;
    logic tgl_seen_q, tgl_seen_d;

    always_comb begin
        tgl_seen_d = tgl_q;
        hp_d = hp_q + 8'h01;
        if (tgl_q != tgl_seen_q) begin
            hp_d = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hp_q <= 8'hFF;
            tgl_seen_q <= 1'b0;
        end else begin
            hp_q <= hp_d;
            tgl_seen_q <= tgl_seen_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_reset_en;
        $fell(rst) |-> en_q == CSAE_EN_RST;
    endproperty
    a_reset_en: assert property (p_reset_en)
        else $error("area enables wrong after reset");

    property p_accept;
        acc_req.valid && en_q[acc_req.area]
            |=> cs_q == onehot($past(acc_req.area)) && !ign_q;
    endproperty
    a_accept: assert property (p_accept)
        else $error("enabled area did not strobe");

    property p_ignore;
        acc_req.valid && !en_q[acc_req.area] |=> cs_q == 8'h00 && ign_q;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("disabled area access was not ignored");

    property p_no_spurious;
        !acc_req.valid |=> cs_q == 8'h00 ##0 !ign_q;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("strobe without request");

    property p_strobe_enabled;
        cs_q != 8'h00 |-> (cs_q & ~$past(en_q)) == 8'h00;
    endproperty
    a_strobe_enabled: assert property (p_strobe_enabled)
        else $error("strobe on a disabled area");

    property p_en_hold;
        !en_wr |=> $stable(en_q);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enables changed without write");

    property p_sd_off;
        !dram_clock_output_enable [*2] |=> !sync_dram_clock_out_q.oe && !sync_dram_clock_out_q.level;
    endproperty
    a_sd_off: assert property (p_sd_off)
        else $error("dram clock still driven");

    property p_same_freq;
        sync_dram_clock_out_q.oe && bclk_q.oe |-> sync_dram_clock_out_q.level == bclk_q.level;
    endproperty
    a_same_freq: assert property (p_same_freq)
        else $error("bus and dram clocks differ");

    property p_half_period;
        $changed(tgl_q) |-> hp_q == 8'(CLK_HALF - 1);
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("shared clock half period wrong");

    property p_half_bound;
        hp_q == 8'hFF || hp_q < 8'(CLK_HALF);
    endproperty
    a_half_bound: assert property (p_half_bound)
        else $error("shared clock stopped toggling");

    property p_strobe_onehot;
        $onehot0(cs_q);
    endproperty
    a_strobe_onehot: assert property (p_strobe_onehot)
        else $error("more than one area strobed");

    property p_strobe_excl;
        !(ign_q && cs_q != 8'h00);
    endproperty
    a_strobe_excl: assert property (p_strobe_excl)
        else $error("ignored access also strobed");

    property p_en_write;
        en_wr |=> en_q == $past(en_wdata);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable write did not land");

    property p_sd_on;
        dram_clock_output_enable |=> sync_dram_clock_out_q.oe && sync_dram_clock_out_q.level == tgl_q;
    endproperty
    a_sd_on: assert property (p_sd_on)
        else $error("dram clock not driven from the shared toggle");

    property p_bus_on;
        bus_clock_output_pin |=> bclk_q.oe && bclk_q.level == tgl_q;
    endproperty
    a_bus_on: assert property (p_bus_on)
        else $error("bus clock not driven from the shared toggle");

    property p_bus_off;
        !bus_clock_output_pin |=> !bclk_q.oe && !bclk_q.level;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus clock driven while unused");

    property p_reset_pins;
        $fell(rst) |-> !sync_dram_clock_out_q.oe && !bclk_q.oe;
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("clock pins driven straight after reset");

    c_accept: cover property (acc_req.valid && en_q[acc_req.area]);
    c_ignore: cover property (acc_req.valid && !en_q[acc_req.area]);
    c_sd_stop: cover property (sync_dram_clock_out_q.oe ##1 !sync_dram_clock_out_q.oe);
    c_en_write: cover property (en_wr ##1 en_q != CSAE_EN_RST);
    c_both_on: cover property (sync_dram_clock_out_q.oe && bclk_q.oe);
endmodule : csae_top

// ---- tb/csae_mem_model.sv ----
/* far-side memory stand-in: counts bus cycles started on any area.
   assumes one-hot strobes registered on core_clk. */
`timescale 1ns/1ns
module csae_mem_model
    import csae_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CSAE_AREAS-1:0] cs_strobe,
    output logic [7:0] cyc_cnt_q
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cyc_cnt_q <= 8'h00;
        end else if (cs_strobe != '0) begin
            cyc_cnt_q <= cyc_cnt_q + 8'h01;
        end
    end
endmodule : csae_mem_model

// ---- tb/tb_top.sv ----
/* self-checking bench of the area enable block.
   assumes inputs change on the falling edge, outputs settle by it. */
`timescale 1ns/1ns
module tb_top
    import csae_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, en_wr = 1'b0, dram_en = 1'b0;
    logic bus_pin = 1'b0, acc_ignored;
    logic [7:0] en_wdata = 8'h00, area_en, cs_strobe, cyc;
    csae_req_s acc_req = '0;
    csae_clk_pin_s bus_clk_pin, dram_clk;
    int miscompares = 0, tests_run = 0;
    csae_top i_csae_top (.core_clk(core_clk), .rst(rst), .en_wr(en_wr),
        .en_wdata(en_wdata), .acc_req(acc_req),
        .dram_clock_output_enable(dram_en), .bus_clock_output_pin(bus_pin),
        .area_operation_enable(area_en), .cs_strobe(cs_strobe),
        .acc_ignored(acc_ignored), .bus_clk_pin(bus_clk_pin),
        .sync_dram_clock_out(dram_clk));
    csae_mem_model i_csae_mem_model (.core_clk(core_clk), .rst(rst),
        .cs_strobe(cs_strobe), .cyc_cnt_q(cyc));
    initial forever #25 core_clk = ~core_clk;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // caller starts on a falling edge and drops valid afterwards
    task access(input logic [2:0] a, input logic [7:0] s, input logic ig);
        acc_req = '{valid: 1'b1, area: a};
        @(negedge core_clk);
        check(cs_strobe, s);
        check(8'(acc_ignored), 8'(ig));
    endtask : access
    task t_access;
        access(3'h0, 8'h01, 1'b0);
        access(3'h3, 8'h00, 1'b1);
        // a write in the same cycle is not yet seen by the access
        en_wr = 1'b1;
        en_wdata = 8'hA5;
        access(3'h7, 8'h00, 1'b1);
        en_wr = 1'b0;
        check(area_en, 8'hA5);
        for (int i = 0; i < 8; i++) begin
            access(i[2:0], 8'hA5 & (8'h01 << i), ~en_wdata[i]);
        end
        acc_req.valid = 1'b0;
        @(negedge core_clk);
        check(cyc, 8'h05);
    endtask : t_access
    task t_clock;
        logic prev;
        logic [7:0] flips;
        flips = 8'h00;
        check(8'(bus_clk_pin), 8'h00);
        dram_en = 1'b1;
        bus_pin = 1'b1;
        repeat (2) @(negedge core_clk);
        prev = dram_clk.level;
        repeat (8) begin
            @(negedge core_clk);
            check(8'(dram_clk), 8'(bus_clk_pin));
            flips = flips + 8'(dram_clk.level != prev);
            prev = dram_clk.level;
        end
        check(flips, 8'(8 / CSAE_CLK_HALF));
        check(8'(dram_clk.oe), 8'h01);
        dram_en = 1'b0;
        @(negedge core_clk);
        check(8'(dram_clk), 8'h00);
        check(8'(bus_clk_pin.oe), 8'h01);
    endtask : t_clock
    task t_reset;
        rst = 1'b1;
        @(negedge core_clk);
        check(8'(bus_clk_pin), 8'h00);
        check(area_en, 8'h01);
        rst = 1'b0;
        check(cyc, 8'h00);
        access(3'h0, 8'h01, 1'b0);
        acc_req.valid = 1'b0;
        check(area_en, 8'h01);
        @(negedge core_clk);
        check(cyc, 8'h01);
        check(8'(bus_clk_pin.oe), 8'h01);
    endtask : t_reset
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        check(area_en, 8'h01);
        t_access;
        t_clock;
        t_reset;
        final_report;
    end
endmodule : tb_top
